// file: src/sfo_consts.svh
`ifndef SFO_CONSTS_SVH
`define SFO_CONSTS_SVH
// fifo geometry (depth fixed at the smallest member)
`define SFO_DEPTH 64
`define SFO_AW 6
`define SFO_DW 9
// offset register sequence positions
`define SFO_SEL_EMPTY_LO 2'h0
`define SFO_SEL_EMPTY_HI 2'h1
`define SFO_SEL_FULL_LO 2'h2
`define SFO_SEL_FULL_HI 2'h3
// offset reset values
`define SFO_EMPTY_OFS_RST 16'h0007
`define SFO_FULL_OFS_RST 16'h0007
`endif

// file: src/sfo_pkg.sv
package sfo_pkg;
   typedef logic [8:0] sfo_word_type;
   typedef struct packed {
      logic write_enable_primary;
      logic load_select;
      sfo_word_type data;
   } sfo_wr_type;
   typedef struct packed {
      logic read_enable_a;
      logic read_enable_b;
   } sfo_rd_type;
   typedef struct packed {
      logic empty_flag_n;
      logic full_flag_n;
      logic almost_empty_flag_n;
      logic almost_full_flag_n;
   } sfo_flags_type;
endpackage

// file: src/sfo_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfo_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // level in and out
   input wire logic d_i,
   output logic q_o
);
   logic meta_r;
   // first stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule
`default_nettype wire

// file: src/sfo_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfo_consts.svh"
module sfo_mem (
   // clock
   input wire logic clk_i,
   // write port
   input wire logic we_i,
   input wire logic [`SFO_AW-1:0] waddr_i,
   input wire sfo_pkg::sfo_word_type wdata_i,
   // read port
   input wire logic [`SFO_AW-1:0] raddr_i,
   output sfo_pkg::sfo_word_type rdata_o
);
   import sfo_pkg::*;
   sfo_word_type mem_r [0:`SFO_DEPTH-1];
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_r[waddr_i] <= wdata_i;
      end
   end
   always_ff @(posedge clk_i) begin
      rdata_o <= mem_r[raddr_i];
   end
endmodule
`default_nettype wire

// file: src/sfo_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfo_consts.svh"
module sfo_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic reset_n_i,
   // link clocks from the two agents
   input wire logic wclk_i,
   input wire logic rclk_i,
   // write and read controls
   input wire sfo_pkg::sfo_wr_type wr_i,
   input wire sfo_pkg::sfo_rd_type rd_i,
   // data and flags out
   output sfo_pkg::sfo_word_type q_o,
   output sfo_pkg::sfo_flags_type flags_o
);
   import sfo_pkg::*;
   localparam int AW = `SFO_AW;
   // ==========================================
   // input synchronisers
   // ==========================================
   localparam int NS = 14;
   logic [NS-1:0] raw_in;
   logic [NS-1:0] syn_in;
   assign raw_in = {reset_n_i, wclk_i, rclk_i, wr_i.write_enable_primary, wr_i.load_select,
                    rd_i.read_enable_a, rd_i.read_enable_b, wr_i.data[6:0]};
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         sfo_sync u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .d_i(raw_in[gi]),
            .q_o(syn_in[gi])
         );
      end
   endgenerate
   logic [1:0] dhi_s;
   sfo_sync u_s7 (.clk_i(clk_i), .rst_i(rst_i), .d_i(wr_i.data[7]), .q_o(dhi_s[0]));
   sfo_sync u_s8 (.clk_i(clk_i), .rst_i(rst_i), .d_i(wr_i.data[8]), .q_o(dhi_s[1]));
   logic res_n, wclk_s, rclk_s, write_enable_primary_s, ld_s, ren_a_s, ren_b_s;
   sfo_word_type din_s;
   assign res_n = syn_in[13];
   assign wclk_s = syn_in[12];
   assign rclk_s = syn_in[11];
   assign write_enable_primary_s = syn_in[10];
   assign ld_s = syn_in[9];
   assign ren_a_s = syn_in[8];
   assign ren_b_s = syn_in[7];
   assign din_s = {dhi_s, syn_in[6:0]};
   // ==========================================
   // clock edge detection
   // ==========================================
   // edges come from synchronised copies, so agent clocks must be far slower than clk_i
   logic wclk_d_r, rclk_d_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wclk_d_r <= 1'b0;
         rclk_d_r <= 1'b0;
      end else begin
         wclk_d_r <= wclk_s;
         rclk_d_r <= rclk_s;
      end
   end
   logic wedge, redge;
   assign wedge = wclk_s & ~wclk_d_r & res_n;
   assign redge = rclk_s & ~rclk_d_r & res_n;
   // ==========================================
   // configuration strap
   // ==========================================
   logic load_cfg_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         load_cfg_r <= 1'b0;
      end else if (!res_n) begin
         load_cfg_r <= ~ld_s;
      end
   end
   // ==========================================
   // decode helpers
   // ==========================================
   // offset access window: load configuration with load_select held low
   function automatic logic in_load(input logic cfg, input logic ld);
      return cfg & ~ld;
   endfunction
   // ==========================================
   // operation decode
   // ==========================================
   logic full_n_r, empty_n_r;
   logic ofs_wr, ofs_rd, fifo_wr, fifo_rd, wr_en_ok;
   always_comb begin
      if (load_cfg_r) begin
         wr_en_ok = ~write_enable_primary_s & ld_s;
      end else begin
         wr_en_ok = ~write_enable_primary_s & ld_s;
      end
   end
   assign ofs_wr = wedge & in_load(load_cfg_r, ld_s) & ~write_enable_primary_s;
   assign fifo_wr = wedge & wr_en_ok & full_n_r;
   assign ofs_rd = redge & in_load(load_cfg_r, ld_s) & ~ren_a_s & ~ren_b_s;
   // offset reads take the read edge, so the fifo is left untouched meanwhile
   assign fifo_rd = redge & ~ren_a_s & ~ren_b_s & empty_n_r & ~in_load(load_cfg_r, ld_s);
   // ==========================================
   // offset registers
   // ==========================================
   logic [7:0] ofs_r [0:3];
   logic [1:0] wsel_r, rsel_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ofs_r[0] <= 8'(`SFO_EMPTY_OFS_RST);
         ofs_r[1] <= 8'(`SFO_EMPTY_OFS_RST >> 8);
         ofs_r[2] <= 8'(`SFO_FULL_OFS_RST);
         ofs_r[3] <= 8'(`SFO_FULL_OFS_RST >> 8);
      end else if (!res_n) begin
         ofs_r[0] <= 8'(`SFO_EMPTY_OFS_RST);
         ofs_r[1] <= 8'(`SFO_EMPTY_OFS_RST >> 8);
         ofs_r[2] <= 8'(`SFO_FULL_OFS_RST);
         ofs_r[3] <= 8'(`SFO_FULL_OFS_RST >> 8);
      end else if (ofs_wr) begin
         ofs_r[wsel_r] <= din_s[7:0];
      end
   end
   // position survives load_select going high; only reset or a write at the last position returns it to the start
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wsel_r <= `SFO_SEL_EMPTY_LO;
      end else if (!res_n) begin
         wsel_r <= `SFO_SEL_EMPTY_LO;
      end else if (ofs_wr) begin
         wsel_r <= wsel_r + 2'h1;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rsel_r <= `SFO_SEL_EMPTY_LO;
      end else if (!res_n) begin
         rsel_r <= `SFO_SEL_EMPTY_LO;
      end else if (ofs_rd) begin
         rsel_r <= rsel_r + 2'h1;
      end
   end
   logic [15:0] n_ofs, m_ofs;
   assign n_ofs = {ofs_r[1], ofs_r[0]};
   assign m_ofs = {ofs_r[3], ofs_r[2]};
   // ==========================================
   // pointers and storage
   // ==========================================
   logic [AW:0] wptr_r, rptr_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr_r <= '0;
      end else if (!res_n) begin
         wptr_r <= '0;
      end else if (fifo_wr) begin
         wptr_r <= wptr_r + 7'h01;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rptr_r <= '0;
      end else if (!res_n) begin
         rptr_r <= '0;
      end else if (fifo_rd) begin
         rptr_r <= rptr_r + 7'h01;
      end
   end
   sfo_word_type mem_q;
   sfo_mem u_mem (
      .clk_i(clk_i),
      .we_i(fifo_wr),
      .waddr_i(wptr_r[AW-1:0]),
      .wdata_i(din_s),
      .raddr_i(rptr_r[AW-1:0]),
      .rdata_o(mem_q)
   );
   // memory answers one cycle late, so the read is presented on the following cycle
   logic fifo_rd_d_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fifo_rd_d_r <= 1'b0;
      end else begin
         fifo_rd_d_r <= fifo_rd;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_o <= '0;
      end else if (!res_n) begin
         q_o <= '0;
      end else if (ofs_rd) begin
         q_o <= {1'b0, ofs_r[rsel_r]};
      end else if (fifo_rd_d_r) begin
         q_o <= mem_q;
      end
   end
   // ==========================================
   // flags
   // ==========================================
   // count after the edge's own transfer, so each flag reflects the updated fill
   logic [AW:0] cnt_nxt;
   logic [16:0] free_nxt;
   always_comb begin
      cnt_nxt = wptr_r - rptr_r + {6'h00, fifo_wr} - {6'h00, fifo_rd};
      free_nxt = 17'(`SFO_DEPTH) - {10'h000, cnt_nxt};
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         empty_n_r <= 1'b0;
         flags_o.empty_flag_n <= 1'b0;
         flags_o.almost_empty_flag_n <= 1'b0;
      end else if (!res_n) begin
         empty_n_r <= 1'b0;
         flags_o.empty_flag_n <= 1'b0;
         flags_o.almost_empty_flag_n <= 1'b0;
      end else if (redge) begin
         empty_n_r <= (cnt_nxt != '0);
         flags_o.empty_flag_n <= (cnt_nxt != '0);
         flags_o.almost_empty_flag_n <= ({10'h000, cnt_nxt} > n_ofs);
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         full_n_r <= 1'b1;
         flags_o.full_flag_n <= 1'b1;
         flags_o.almost_full_flag_n <= 1'b1;
      end else if (!res_n) begin
         full_n_r <= 1'b1;
         flags_o.full_flag_n <= 1'b1;
         flags_o.almost_full_flag_n <= 1'b1;
      end else if (wedge) begin
         full_n_r <= (free_nxt != '0);
         flags_o.full_flag_n <= (free_nxt != '0);
         flags_o.almost_full_flag_n <= (free_nxt > {1'b0, m_ofs});
      end
   end
   // ==========================================
   // checks
   // ==========================================
   a_full_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
      !full_n_r |-> !fifo_wr) else $error("write while full");
   a_empty_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
      !empty_n_r |-> !fifo_rd) else $error("read while empty");
   a_wsel_step: assert property (@(posedge clk_i) disable iff (rst_i)
      ofs_wr && res_n |=> wsel_r == $past(wsel_r) + 2'h1) else $error("offset write order");
   a_rsel_step: assert property (@(posedge clk_i) disable iff (rst_i)
      ofs_rd && res_n |=> rsel_r == $past(rsel_r) + 2'h1) else $error("offset read order");
   a_wsel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !ofs_wr && res_n |=> $stable(wsel_r)) else $error("position lost");
   a_ofs_store: assert property (@(posedge clk_i) disable iff (rst_i)
      ofs_wr && res_n |=> ofs_r[$past(wsel_r)] == $past(din_s[7:0])) else $error("offset not stored");
   a_reset_empty: assert property (@(posedge clk_i) disable iff (rst_i)
      !res_n |=> !flags_o.empty_flag_n && wptr_r == rptr_r) else $error("reset not empty");
   a_no_ld_write: assert property (@(posedge clk_i) disable iff (rst_i)
      load_cfg_r && !ld_s |-> !fifo_wr) else $error("fifo write during load");
   a_pae_level: assert property (@(posedge clk_i) disable iff (rst_i)
      redge && res_n |=> flags_o.almost_empty_flag_n == ({10'h000, $past(cnt_nxt)} > $past(n_ofs)))
      else $error("almost empty wrong");
   // strap is frozen once the device reset is released
   a_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      res_n |=> $stable(load_cfg_r)) else $error("configuration changed");
   a_wsel_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      ofs_wr && wsel_r == `SFO_SEL_FULL_HI |=> wsel_r == `SFO_SEL_EMPTY_LO)
      else $error("offset write no wrap");
   a_ofs_default: assert property (@(posedge clk_i) disable iff (rst_i)
      !res_n |=> n_ofs == `SFO_EMPTY_OFS_RST && m_ofs == `SFO_FULL_OFS_RST)
      else $error("offset default wrong");
   a_full_level: assert property (@(posedge clk_i) disable iff (rst_i)
      wedge |=> flags_o.full_flag_n == ($past(free_nxt) != '0)) else $error("full flag wrong");
   a_empty_level: assert property (@(posedge clk_i) disable iff (rst_i)
      redge |=> flags_o.empty_flag_n == ($past(cnt_nxt) != '0)) else $error("empty flag wrong");
   a_paf_level: assert property (@(posedge clk_i) disable iff (rst_i)
      wedge |=> flags_o.almost_full_flag_n == ($past(free_nxt) > {1'b0, $past(m_ofs)}))
      else $error("almost full wrong");
   // write-side flags move only on write edges
   a_full_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      !wedge && res_n |=> $stable(flags_o.full_flag_n) && $stable(flags_o.almost_full_flag_n))
      else $error("full flags off edge");
   // read-side flags move only on read edges
   a_empty_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      !redge && res_n |=> $stable(flags_o.empty_flag_n) && $stable(flags_o.almost_empty_flag_n))
      else $error("empty flags off edge");
   a_data_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wedge && ld_s && !write_enable_primary_s && full_n_r |-> fifo_wr) else $error("fifo write lost");
   a_ofs_readout: assert property (@(posedge clk_i) disable iff (rst_i)
      ofs_rd |=> q_o == {1'b0, $past(ofs_r[rsel_r])}) else $error("offset readout wrong");
   c_wsel_wrap: cover property (@(posedge clk_i) ofs_wr && wsel_r == `SFO_SEL_FULL_HI);
   c_ofs_write: cover property (@(posedge clk_i) ofs_wr);
   c_ofs_read: cover property (@(posedge clk_i) ofs_rd);
   c_full: cover property (@(posedge clk_i) !flags_o.full_flag_n);
   c_pae_high: cover property (@(posedge clk_i) flags_o.almost_empty_flag_n);
endmodule
`default_nettype wire

// file: test/sfo_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// host agent on the write and read ports
module sfo_host
   import sfo_pkg::*;
(
   // system clock
   input wire logic clk_i,
   // agent clocks, free running
   output var logic wclk_o,
   output var logic rclk_o,
   // port controls
   output var sfo_pkg::sfo_wr_type wr_o,
   output var sfo_pkg::sfo_rd_type rd_o
);
   initial begin
      wclk_o = 1'b0;
      wr_o = '{1'b1, 1'b1, 9'h000};
      rd_o = 2'h3;
      forever #100 wclk_o = ~wclk_o;
   end
   // read clock offset so the agents never share a phase
   initial begin
      rclk_o = 1'b0;
      #37;
      forever #100 rclk_o = ~rclk_o;
   end
   // ==========
   // drivers
   // strap is set with the device reset and held through it
   task automatic strap(input logic ld);
      @(posedge clk_i);
      wr_o <= '{1'b1, ld, 9'h000};
   endtask
   // controls change mid low phase and stand across one edge only
   task automatic wr_op(input logic ld, input logic wen, input sfo_word_type d);
      @(posedge wclk_o);
      repeat (5) @(posedge clk_i);
      wr_o <= '{wen, ld, d};
      @(posedge wclk_o);
      repeat (7) @(posedge clk_i);
      wr_o <= '{1'b1, ld, ~d};
   endtask
   task automatic rd_op(input sfo_rd_type r);
      @(posedge rclk_o);
      repeat (5) @(posedge clk_i);
      rd_o <= r;
      @(posedge rclk_o);
      repeat (7) @(posedge clk_i);
      rd_o <= 2'h3;
   endtask
endmodule
`default_nettype wire

// file: test/sync_fifo_offset_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
`define SFO_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module sync_fifo_offset_flags_test;
   import sfo_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic reset_n_i = 1'b0;
   logic wclk;
   logic rclk;
   sfo_wr_type wr;
   sfo_rd_type rd;
   sfo_word_type q;
   sfo_flags_type fl;
   int failures = 0;
   int num_checks = 0;
   always #12.5 clk_i = ~clk_i;
   sfo_host u_sfo_host (.clk_i(clk_i), .wclk_o(wclk), .rclk_o(rclk), .wr_o(wr), .rd_o(rd));
   sfo_top u_sfo_top (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .wclk_i(wclk), .rclk_i(rclk),
      .wr_i(wr), .rd_i(rd), .q_o(q), .flags_o(fl));
   // ==========
   // helpers
   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic dev_reset(input logic ld);
      u_sfo_host.strap(ld);
      reset_n_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      `SFO_CHK("flags", 4'h5, fl)
      `SFO_CHK("q", 9'h000, q)
   endtask
   // ==========
   // two write enables, default offsets
   task automatic t_normal();
      dev_reset(1'b1);
      u_sfo_host.wr_op(1'b0, 1'b0, 9'h155);
      u_sfo_host.rd_op(2'h3);
      `SFO_CHK("empty", 1'b0, fl.empty_flag_n)
      // the last write lands on a full fifo and must be dropped
      for (int i = 1; i <= 65; i++) begin
         u_sfo_host.wr_op(1'b1, 1'b0, 9'(i));
         `SFO_CHK("afull", 1'(i < 57), fl.almost_full_flag_n)
         `SFO_CHK("full", 1'(i < 64), fl.full_flag_n)
      end
      u_sfo_host.rd_op(2'h1);
      `SFO_CHK("q", 9'h000, q)
      `SFO_CHK("empty", 1'b1, fl.empty_flag_n)
      u_sfo_host.rd_op(2'h2);
      `SFO_CHK("q", 9'h000, q)
      for (int i = 1; i <= 65; i++) begin
         u_sfo_host.rd_op(2'h0);
         `SFO_CHK("q", 9'(i < 65 ? i : 64), q)
         `SFO_CHK("aempty", 1'(64 - i > 7), fl.almost_empty_flag_n)
         `SFO_CHK("empty", 1'(i < 64), fl.empty_flag_n)
      end
      u_sfo_host.wr_op(1'b1, 1'b1, 9'h0AA);
      `SFO_CHK("flags", 4'h5, fl)
      $display("normal configuration done");
   endtask
   // ==========
   // load configuration, offset programming
   task automatic t_load();
      sfo_word_type exp[8] = '{9'h007, 9'h000, 9'h007, 9'h000, 9'h003, 9'h000, 9'h004, 9'h000};
      // entries are {wen, load, data}: wrap, load-high gaps and a 1,0 no-op in mid sequence
      sfo_wr_type seq[10] = '{11'h009, 11'h000, 11'h005, 11'h000, 11'h003, 11'h600, 11'h5FF, 11'h000,
         11'h600, 11'h004};
      dev_reset(1'b0);
      for (int i = 0; i < 4; i++) begin
         u_sfo_host.rd_op(2'h0);
         `SFO_CHK("ofs", exp[i], q)
      end
      foreach (seq[i]) u_sfo_host.wr_op(seq[i].load_select, seq[i].write_enable_primary, seq[i].data);
      for (int i = 4; i < 8; i++) begin
         u_sfo_host.rd_op(2'h0);
         `SFO_CHK("ofs", exp[i], q)
      end
      // n is now 3 and m is 4
      for (int i = 1; i <= 60; i++) begin
         u_sfo_host.wr_op(1'b1, 1'b0, 9'(i));
         `SFO_CHK("afull", 1'(i < 60), fl.almost_full_flag_n)
         if (i == 3 || i == 4) begin
            u_sfo_host.rd_op(2'h3);
            `SFO_CHK("aempty", 1'(i == 4), fl.almost_empty_flag_n)
         end
      end
      u_sfo_host.rd_op(2'h0);
      `SFO_CHK("q", 9'h001, q)
      $display("load configuration done");
   endtask
   // ==========
   // sequence and watchdog
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_normal();
      t_load();
      conclude();
   end
   // about 220 port operations of 400 ns each; four times that is ample
   initial begin
      #400000;
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
